// ===== src/icu_capture_unit.sv
// Input capture unit: timer, capture latch, interrupt flag and Wishbone registers.
// Assumes a classic Wishbone master on ref_clk and an outside wire
// that resolves the capture pin from capturePinOut and capturePinOe.
//
// Added by the designer: the address map and register access over Wishbone.
`timescale 1ns/10ps
`include "icu_consts.svh"

module icu_capture_unit (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire icu_pkg::icu_word_t wb_dat_i,
  output icu_pkg::icu_word_t wb_dat_o,
  output logic wb_ack_o,
  // Capture pin
  input wire logic capturePinIn,
  output logic capturePinOut,
  output logic capturePinOe,
  // Timer clock and power
  input wire logic extTimerClkPin,
  input wire logic sleepReq,
  // Interrupt
  output logic irq,
  output logic wakeReq
);
  import icu_pkg::*;

  // Bus request decode
  logic busReq;
  logic busWr;
  logic busRd;
  logic hitCtrl;
  logic hitValLo;
  logic hitValHi;
  logic hitIrqEn;
  logic hitIrqFlag;
  logic hitTmrLo;
  logic hitTmrHi;
  logic hitTmrCtrl;
  logic hitPinCtrl;
  icu_byte_t wrByte;
  icu_byte_t rdByte;

  // Registers
  logic wbAck_reg;
  icu_word_t rdData_reg;
  icu_byte_t ctrl_reg;
  icu_byte_t ctrl_next;
  icu_count_t capValue_reg;
  icu_count_t capValue_next;
  logic capIrqEn_reg;
  logic capIrqFlag_reg;
  logic capIrqFlag_next;
  icu_count_t timerCount_reg;
  icu_count_t timerCount_next;
  logic timerOn_reg;
  logic timerExt_reg;
  logic pinData_reg;
  logic pinOe_reg;
  logic irq_reg;
  logic wake_reg;

  // Derived control
  icu_mode_t mode;
  logic capEvent;
  logic timerTick;
  logic asleep;

  // Synchronized outside inputs
  icu_edge_if capEdge ();
  icu_edge_if extClkEdge ();
  icu_edge_if sleepEdge ();

  // The pin wire is watched whatever its direction, so port writes can capture
  icu_pin_sync u_cap_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .pinIn(capturePinIn),
    .edge_o(capEdge)
  );

  icu_pin_sync u_ext_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .pinIn(extTimerClkPin),
    .edge_o(extClkEdge)
  );

  icu_pin_sync u_sleep_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .pinIn(sleepReq),
    .edge_o(sleepEdge)
  );

  icu_prescaler #(
    .CNT_W(4)
  ) u_prescaler (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .mode(mode),
    .edge_i(capEdge),
    .capEvent(capEvent)
  );

  // Bus decode
  assign busReq = wb_cyc_i & wb_stb_i & ~wbAck_reg;
  assign busWr = busReq & wb_we_i & wb_sel_i[0];
  assign busRd = busReq & ~wb_we_i;
  assign wrByte = wb_dat_i[7:0];
  assign hitCtrl = (wb_adr_i == `ICU_ADDR_CTRL);
  assign hitValLo = (wb_adr_i == `ICU_ADDR_VAL_LO);
  assign hitValHi = (wb_adr_i == `ICU_ADDR_VAL_HI);
  assign hitIrqEn = (wb_adr_i == `ICU_ADDR_IRQ_EN);
  assign hitIrqFlag = (wb_adr_i == `ICU_ADDR_IRQ_FLAG);
  assign hitTmrLo = (wb_adr_i == `ICU_ADDR_TMR_LO);
  assign hitTmrHi = (wb_adr_i == `ICU_ADDR_TMR_HI);
  assign hitTmrCtrl = (wb_adr_i == `ICU_ADDR_TMR_CTRL);
  assign hitPinCtrl = (wb_adr_i == `ICU_ADDR_PIN_CTRL);

  // Read selection; unmapped addresses read zero
  assign rdByte =
    hitCtrl ? {2'h0, ctrl_reg[5:0]} :
    hitValLo ? capValue_reg[7:0] :
    hitValHi ? capValue_reg[15:8] :
    hitIrqEn ? {7'h00, capIrqEn_reg} :
    hitIrqFlag ? {7'h00, capIrqFlag_reg} :
    hitTmrLo ? timerCount_reg[7:0] :
    hitTmrHi ? timerCount_reg[15:8] :
    hitTmrCtrl ? {6'h00, timerExt_reg, timerOn_reg} :
    hitPinCtrl ? {6'h00, ~pinOe_reg, pinData_reg} : 8'h00;

  // Control register; bits 7:6 are not implemented
  assign ctrl_next = (busWr & hitCtrl) ? {2'h0, wrByte[5:0]} : ctrl_reg;
  assign mode = icu_mode_t'(ctrl_reg[`ICU_CTRL_MODE_LSB +: 4]);

  // Timer: internal source stops while asleep, external pin keeps counting
  assign asleep = sleepEdge.level;
  assign timerTick = timerOn_reg &
                     (timerExt_reg ? extClkEdge.rise : ~asleep);
  assign timerCount_next =
    (busWr & hitTmrLo) ? {timerCount_reg[15:8], wrByte} :
    (busWr & hitTmrHi) ? {wrByte, timerCount_reg[7:0]} :
    timerTick ? timerCount_reg + 16'h0001 : timerCount_reg;

  // Capture latch: a capture beats a software write and overwrites old data
  assign capValue_next =
    capEvent ? timerCount_reg :
    (busWr & hitValLo) ? {capValue_reg[15:8], wrByte} :
    (busWr & hitValHi) ? {wrByte, capValue_reg[7:0]} : capValue_reg;

  // Sticky flag, write one to clear; a capture in the same cycle wins
  assign capIrqFlag_next =
    capEvent |
    (capIrqFlag_reg & ~(busWr & hitIrqFlag & wrByte[`ICU_IRQ_CAPTURE_BIT]));

  // Bus handshake
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wbAck_reg <= 1'b0;
      rdData_reg <= 32'h0000_0000;
    end else begin
      wbAck_reg <= busReq;
      rdData_reg <= busRd ? {24'h00_0000, rdByte} : rdData_reg;
    end
  end

  // Capture control and captured value
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl_reg <= `ICU_CTRL_RESET;
      capValue_reg <= 16'h0000;
    end else begin
      ctrl_reg <= ctrl_next;
      capValue_reg <= capValue_next;
    end
  end

  // Interrupt enable and flag
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      capIrqEn_reg <= 1'b0;
      capIrqFlag_reg <= 1'b0;
    end else begin
      if (busWr & hitIrqEn) begin
        capIrqEn_reg <= wrByte[`ICU_IRQ_CAPTURE_BIT];
      end
      capIrqFlag_reg <= capIrqFlag_next;
    end
  end

  // Shared timer
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      timerCount_reg <= 16'h0000;
      timerOn_reg <= 1'b0;
      timerExt_reg <= 1'b0;
    end else begin
      timerCount_reg <= timerCount_next;
      if (busWr & hitTmrCtrl) begin
        timerOn_reg <= wrByte[`ICU_TMR_ON_BIT];
        timerExt_reg <= wrByte[`ICU_TMR_EXT_BIT];
      end
    end
  end

  // Port latch and direction of the capture pin; reset leaves it an input
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pinData_reg <= 1'b0;
      pinOe_reg <= 1'b0;
    end else if (busWr & hitPinCtrl) begin
      pinData_reg <= wrByte[`ICU_PIN_DATA_BIT];
      pinOe_reg <= ~wrByte[`ICU_PIN_DIR_BIT];
    end
  end

  // Interrupt and wake outputs follow the flag one cycle later
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      irq_reg <= 1'b0;
      wake_reg <= 1'b0;
    end else begin
      irq_reg <= capIrqFlag_reg & capIrqEn_reg;
      wake_reg <= capIrqFlag_reg & capIrqEn_reg & asleep;
    end
  end

  assign wb_ack_o = wbAck_reg;
  assign wb_dat_o = rdData_reg;
  assign capturePinOut = pinData_reg;
  assign capturePinOe = pinOe_reg;
  assign irq = irq_reg;
  assign wakeReq = wake_reg;
endmodule : icu_capture_unit

// ===== src/icu_consts.svh
// Constants of the input capture unit: offsets, fields, reset values, mode codes.
// Assumes a 32-bit classic Wishbone slave with byte addresses on wb_adr_i.
// Overview of operation
// - Capture copies full 16-bit timer count.
// - Mode selects fall, rise, 4th, 16th rise.
// - Each capture sets the capture interrupt flag.
// - New capture overwrites unread value, no overrun.
// - Edge detector watches pin even when driven.
// - Prescaler cleared when off or not capture.
// - Any reset clears the prescaler counter.
// - Capture prescale change keeps the old count.
// - Capture and wake keep working in sleep.
// - Stopped timer source holds count until wake.
`ifndef ICU_CONSTS_SVH
`define ICU_CONSTS_SVH

`define ICU_ADDR_CTRL 8'h00
`define ICU_ADDR_VAL_LO 8'h04
`define ICU_ADDR_VAL_HI 8'h08
`define ICU_ADDR_IRQ_EN 8'h0C
`define ICU_ADDR_IRQ_FLAG 8'h10
`define ICU_ADDR_TMR_LO 8'h14
`define ICU_ADDR_TMR_HI 8'h18
`define ICU_ADDR_TMR_CTRL 8'h1C
`define ICU_ADDR_PIN_CTRL 8'h20

`define ICU_MODE_OFF 4'h0
`define ICU_MODE_FALL 4'h4
`define ICU_MODE_RISE 4'h5
`define ICU_MODE_RISE4 4'h6
`define ICU_MODE_RISE16 4'h7

`define ICU_CTRL_MODE_LSB 0
`define ICU_CTRL_DUTY_LSB 4
`define ICU_IRQ_CAPTURE_BIT 0
`define ICU_TMR_ON_BIT 0
`define ICU_TMR_EXT_BIT 1
`define ICU_PIN_DATA_BIT 0
`define ICU_PIN_DIR_BIT 1

`define ICU_CTRL_RESET 8'h00
`define ICU_IRQ_RESET 8'h00
`define ICU_TMR_CTRL_RESET 8'h00
`define ICU_SYNC_STAGES 2

`endif

// ===== src/icu_pkg.sv
// Types shared by the input capture unit.
// Assumes icu_consts.svh is on the include path.
`include "icu_consts.svh"

package icu_pkg;
  typedef logic [31:0] icu_word_t;
  typedef logic [7:0] icu_byte_t;
  typedef logic [15:0] icu_count_t;
  typedef enum logic [3:0] {
    ICU_MODE_OFF_E = `ICU_MODE_OFF,
    ICU_MODE_FALL_E = `ICU_MODE_FALL,
    ICU_MODE_RISE_E = `ICU_MODE_RISE,
    ICU_MODE_RISE4_E = `ICU_MODE_RISE4,
    ICU_MODE_RISE16_E = `ICU_MODE_RISE16
  } icu_mode_t;
endpackage : icu_pkg

// ===== src/icu_edge_if.sv
// Synchronized level and edge pulses of one outside input.
// Assumes producer and consumer share ref_clk.
`timescale 1ns/10ps

interface icu_edge_if;
  logic level;
  logic rise;
  logic fall;
  modport producer (output level, output rise, output fall);
  modport consumer (input level, input rise, input fall);
endinterface : icu_edge_if

// ===== src/icu_pin_sync.sv
// Two-flop synchronizer with edge detection against the previous sampled level.
// Assumes pinIn is asynchronous to ref_clk.
`timescale 1ns/10ps

module icu_pin_sync (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Raw pin
  input wire logic pinIn,
  // Clean edges
  icu_edge_if.producer edge_o
);
  import icu_pkg::*;

  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= pinIn;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign edge_o.level = sync_reg;
  assign edge_o.rise = sync_reg & ~prev_reg;
  assign edge_o.fall = ~sync_reg & prev_reg;
endmodule : icu_pin_sync

// ===== src/icu_prescaler.sv
// Edge prescaler: turns pin edges into qualified capture events.
// Assumes clean one-cycle edge pulses from icu_pin_sync.
`timescale 1ns/10ps

module icu_prescaler #(
  parameter int CNT_W = 4
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Mode and edges
  input wire icu_pkg::icu_mode_t mode,
  icu_edge_if.consumer edge_i,
  // Qualified event
  output logic capEvent
);
  import icu_pkg::*;

  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic isCapture;
  logic wrap4;
  logic wrap16;

  assign isCapture = (mode == ICU_MODE_FALL_E) | (mode == ICU_MODE_RISE_E)
                   | (mode == ICU_MODE_RISE4_E) | (mode == ICU_MODE_RISE16_E);
  // Only the mode code matters, so switching prescale keeps the count
  assign count_next = !isCapture ? '0 :
                      edge_i.rise ? count_reg + 1'b1 : count_reg;
  assign wrap4 = (count_reg[1:0] == 2'h3);
  assign wrap16 = (count_reg == {CNT_W{1'b1}});
  assign capEvent = (mode == ICU_MODE_FALL_E) ? edge_i.fall :
                    (mode == ICU_MODE_RISE_E) ? edge_i.rise :
                    (mode == ICU_MODE_RISE4_E) ? edge_i.rise & wrap4 :
                    (mode == ICU_MODE_RISE16_E) ? edge_i.rise & wrap16 : 1'b0;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end
endmodule : icu_prescaler

// ===== tb/icu_pin_model.sv
// Outside event source on the capture pin.
// Assumes the bench sets drvLevel; the device port wins while enabled.
`timescale 1ns/10ps
module icu_pin_model (
  // Event source
  input wire logic drvLevel,
  // Device port driver
  input wire logic capturePinOut,
  input wire logic capturePinOe,
  // Resolved pin
  output logic pinWire
);
  // Driven pin feeds the edge logic too
  assign pinWire = capturePinOe ? capturePinOut : drvLevel;
endmodule : icu_pin_model

// ===== tb/icu_capture_unit_properties.sv
// Port checker of the capture unit.
// Assumes it is bound onto icu_capture_unit.
`timescale 1ns/10ps
module icu_capture_unit_properties (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire icu_pkg::icu_word_t wb_dat_i,
  input wire icu_pkg::icu_word_t wb_dat_o,
  input wire logic wb_ack_o,
  // Pin and interrupt
  input wire logic capturePinOut,
  input wire logic capturePinOe,
  input wire logic irq,
  input wire logic wakeReq
);
  import icu_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr = req && wb_we_i;
  sequence s_ack; ##1 wb_ack_o ##1 !wb_ack_o; endsequence
  sequence s_mask; wr && wb_adr_i == 8'h0C && wb_sel_i[0] && !wb_dat_i[0]; endsequence
  property p_ack; req |-> s_ack; endproperty
  a_ack: assert property (p_ack) else $error("ack not a single pulse");
  property p_pin; $changed(capturePinOut) |-> $past(wr && wb_adr_i == 8'h20); endproperty
  a_pin: assert property (p_pin) else $error("pin latch moved alone");
  property p_hi; wb_ack_o |-> wb_dat_o[31:8] == 24'h0; endproperty
  a_hi: assert property (p_hi) else $error("upper read data not zero");
  property p_unm; req && !wb_we_i && wb_adr_i == 8'h40 |=> wb_dat_o == 32'h0; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  property p_hold; irq && !wr && !$past(wr) |=> irq; endproperty
  a_hold: assert property (p_hold) else $error("irq dropped alone");
  property p_wake; wakeReq |-> irq; endproperty
  a_wake: assert property (p_wake) else $error("wake without irq");
  property p_rst; $fell(sys_rst) |-> !irq && !wb_ack_o && !capturePinOe; endproperty
  a_rst: assert property (p_rst) else $error("outputs not reset");
  property p_mask; s_mask |-> ##2 !irq; endproperty
  a_mask: assert property (p_mask) else $error("masked irq stays");
endmodule : icu_capture_unit_properties
bind icu_capture_unit icu_capture_unit_properties i_icu_capture_unit_properties (.ref_clk,
  .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
  .wb_ack_o, .capturePinOut, .capturePinOe, .irq, .wakeReq);

// ===== tb/icu_capture_unit_test.sv
// Self-checking bench of the capture unit.
// Assumes design, pin model and checker are compiled first.
`timescale 1ns/10ps
module icu_capture_unit_test;
  import icu_pkg::*;
  logic ref_clk, sys_rst, cyc, we, pinDrv, extClk, sleepReq;
  logic ack, pinOut, pinOe, pinWire, irq, wakeReq;
  icu_byte_t adr, rd, lo;
  icu_word_t dat, datO;
  icu_count_t t;
  int errors, compares, seed;
  icu_capture_unit i_icu_capture_unit (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(dat), .wb_dat_o(datO), .wb_ack_o(ack), .capturePinIn(pinWire),
    .capturePinOut(pinOut), .capturePinOe(pinOe), .extTimerClkPin(extClk),
    .sleepReq(sleepReq), .irq(irq), .wakeReq(wakeReq));
  icu_pin_model i_icu_pin_model (.drvLevel(pinDrv), .capturePinOut(pinOut),
    .capturePinOe(pinOe), .pinWire(pinWire));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) extClk <= 1'($random(seed));
  task automatic chk(input string s, input icu_count_t e, input icu_count_t g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic wb(input logic w, input icu_byte_t a, input icu_byte_t d);
    int n;
    n = 0;
    @(posedge ref_clk);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      $display("[ERR] ack expected 1 seen 0");
    end
    rd = datO[7:0];
    cyc <= 1'b0;
  endtask : wb
  task automatic rdchk(input string s, input icu_byte_t a, input icu_byte_t e);
    wb(1'b0, a, 8'h00);
    chk(s, {8'h00, e}, {8'h00, rd});
  endtask : rdchk
  task automatic capchk();
    wb(1'b0, 8'h04, 8'h00);
    lo = rd;
    wb(1'b0, 8'h08, 8'h00);
    chk("capture", t, {rd, lo});
  endtask : capchk
  task automatic settm();
    t = 16'($random(seed));
    wb(1'b1, 8'h14, t[7:0]);
    wb(1'b1, 8'h18, t[15:8]);
  endtask : settm
  task automatic lvl(input logic v);
    @(posedge ref_clk);
    pinDrv <= v;
    repeat (7) @(posedge ref_clk);
  endtask : lvl
  task automatic rises(input int n);
    repeat (n) begin
      lvl(1'b0);
      lvl(1'b1);
    end
  endtask : rises
  task automatic presc(input icu_byte_t m, input int n, input int k);
    wb(1'b1, 8'h00, 8'h00);
    wb(1'b1, 8'h00, m);
    wb(1'b1, 8'h10, 8'h01);
    rises(n - 1);
    rdchk("early flag", 8'h10, 8'h00);
    rises(k);
    rdchk("presc flag", 8'h10, (k > 0) ? 8'h01 : 8'h00);
  endtask : presc
  task automatic complete_run();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run
  initial begin
    #1000000;
    errors++;
    complete_run();
  end
  initial begin
    seed = 45200;
    {errors, compares} = 0;
    {cyc, we, pinDrv, sleepReq, adr, dat} = '0;
    sys_rst = 1'b1;
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rdchk("pin ctrl", 8'h20, 8'h02);
    wb(1'b1, 8'h00, 8'hFF);
    rdchk("control", 8'h00, 8'h3F);
    wb(1'b1, 8'h40, 8'h55);
    rdchk("unmapped", 8'h40, 8'h00);
    wb(1'b1, 8'h0C, 8'h01);
    wb(1'b1, 8'h00, 8'h05);
    settm();
    rises(1);
    capchk();
    chk("irq", 16'h1, {15'h0, irq});
    settm();
    rises(1);
    capchk();
    rdchk("flag kept", 8'h10, 8'h01);
    wb(1'b1, 8'h00, 8'h04);
    settm();
    lvl(1'b0);
    capchk();
    wb(1'b1, 8'h10, 8'h01);
    lvl(1'b1);
    rdchk("fall only", 8'h10, 8'h00);
    wb(1'b1, 8'h0C, 8'h00);
    presc(8'h06, 4, 1);
    presc(8'h07, 16, 1);
    presc(8'h06, 3, 0);
    wb(1'b1, 8'h00, 8'h07);
    rises(13);
    rdchk("carried count", 8'h10, 8'h00);
    rises(1);
    rdchk("early capture", 8'h10, 8'h01);
    wb(1'b1, 8'h00, 8'h05);
    wb(1'b1, 8'h20, 8'h00);
    settm();
    wb(1'b1, 8'h20, 8'h01);
    repeat (5) @(posedge ref_clk);
    capchk();
    wb(1'b1, 8'h20, 8'h02);
    wb(1'b1, 8'h1C, 8'h01);
    wb(1'b1, 8'h0C, 8'h01);
    @(posedge ref_clk) sleepReq <= 1'b1;
    repeat (5) @(posedge ref_clk);
    wb(1'b0, 8'h14, 8'h00);
    lo = rd;
    repeat (9) @(posedge ref_clk);
    rdchk("held timer", 8'h14, lo);
    wb(1'b1, 8'h10, 8'h01);
    rises(1);
    chk("wake", 16'h1, {15'h0, wakeReq});
    @(posedge ref_clk) sleepReq <= 1'b0;
    wb(1'b1, 8'h0C, 8'h00);
    repeat (3) @(posedge ref_clk);
    chk("masked irq", 16'h0, {15'h0, irq});
    wb(1'b0, 8'h14, 8'h00);
    lo = rd;
    repeat (9) @(posedge ref_clk);
    rdchk("resumed timer", 8'h14, lo + 8'h0C);
    @(posedge ref_clk) sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rdchk("reset control", 8'h00, 8'h00);
    presc(8'h06, 4, 1);
    complete_run();
  end
endmodule : icu_capture_unit_test
